// ### inc/rds_pkg.sv
// Package: constants and types for the reset delay sequencer
package rds_pkg;
    localparam int CLK_MHZ          = 25;
    localparam int POR_DELAY_NS     = 10000;
    localparam int START_REG_NS     = 20000;
    localparam int PUT_MS           = 64;
    localparam int RST_DELAY_NS     = 20000;
    localparam int LOCK_NS          = 20000;
    localparam int MON_DELAY_NS     = 100000;
    // Least times round up to whole cycles
    localparam int POR_CYC   = (POR_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int START_CYC = (START_REG_NS * CLK_MHZ + 999) / 1000;
    localparam int PUT_CYC   = PUT_MS * 1000 * CLK_MHZ;
    localparam int RST_CYC   = (RST_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int LOCK_CYC  = (LOCK_NS * CLK_MHZ + 999) / 1000;
    localparam int MON_CYC   = (MON_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int OST_COUNT = 1024;
    localparam int CNT_W     = 24;
    localparam int OST_W     = 10;
    localparam logic [23:0] RESET_VECTOR = 24'h000000;
    localparam logic [2:0]  OSC_FRC      = 3'h0;

    // Oscillator codes as stored in the select fields
    typedef enum logic [2:0] {
        RDS_OSC_FRC    = 3'b000,
        RDS_OSC_FRCPLL = 3'b001,
        RDS_OSC_XT     = 3'b010,
        RDS_OSC_XTPLL  = 3'b011,
        RDS_OSC_SECONDARY_OSCILLATOR   = 3'b100,
        RDS_OSC_INTERNAL_LOW_POWER_RC_OSC   = 3'b101,
        RDS_OSC_EC     = 3'b110,
        RDS_OSC_ECPLL  = 3'b111
    } rds_osc_t;

    typedef struct packed {
        logic power_on;
        logic brown_out_reset;
        logic external_pin_reset;
        logic instruction_reset;
        logic watchdog_reset;
        logic trap_conflict;
        logic illegal_opcode;
    } rds_src_t;

    typedef enum logic [2:0] {
        RDS_IDLE  = 3'b000,
        RDS_POR   = 3'b001,
        RDS_START = 3'b010,
        RDS_RST   = 3'b011,
        RDS_MON   = 3'b100,
        RDS_RUN   = 3'b101
    } rds_state_t;
endpackage : rds_pkg

// ### rtl/rds_sync.sv
// Two-stage synchroniser for a bus of pin levels
`timescale 1ns/1ps
module rds_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else if (clk_en) begin
            meta_ff <= d_in;
            q_ff    <= meta_ff;
        end
    end
    assign q_out = q_ff;
endmodule : rds_sync

// ### rtl/rds_sequencer.sv
// Reset delay sequencer: clock choice, reset delays, oscillator waits, monitor start
// Function
// R1: Master reset is active while any reset source is active.
// R2: Switching on: power-on/brown-out take nv select; other resets keep current field.
// R3: Switching off: every reset takes clock from nv select only.
// R4: Master reset releases only after applicable power-on and start-up delays expire.
// R5: Oscillator start count and PLL lock run alongside the reset delays.
// R6: Power-on adds 10 us delay first; brown-out skips it.
// R7: Start-up is 20 us with regulator on, 64 ms without.
// R8: With regulator on, start-up delay also applies on wake from sleep.
// R9: 20 us internal reset time; other resets apply only it.
// R10: Crystal and secondary sources count 1024 oscillator periods before release.
// R11: PLL sources wait 20 us lock, after start count when crystal feeds.
// R12: No code runs until a valid clock is released.
// R13: Monitor on and no valid clock: switch to fast RC, raise trap.
// R14: Crystal/PLL sources insert monitor delay after reset delays before monitoring.
// R15: Only reset and oscillator control values depend on reset type.
// R16: Any reset clears state, zeroes program counter, fetches at zero.
`timescale 1ns/1ps
module rds_sequencer #(
    parameter int PUT_CYCLES = rds_pkg::PUT_CYC
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    input  rds_pkg::rds_src_t     reset_sources,
    input  wire logic             clock_switch_en,
    input  wire logic             regulator_en,
    input  wire logic             fail_safe_clock_monitor_en,
    input  wire logic [2:0]       nv_oscillator_select,
    input  wire logic             sleep_wake,
    input  wire logic             osc_tick,
    input  wire logic             pll_locked,
    input  wire logic             clock_valid,
    output logic                  master_reset_signal,
    output logic                  cpu_run,
    output logic [23:0]           fetch_address,
    output logic [2:0]            current_oscillator_field,
    output logic                  clock_released,
    output logic                  clock_fail_trap,
    output logic                  monitor_active
);
    rds_pkg::rds_src_t  src_s;
    logic               tick_s;
    logic               lock_s;
    logic               valid_s;
    logic               wake_s;
    rds_pkg::rds_state_t state_ff;
    rds_pkg::rds_state_t nxt_state;
    logic [rds_pkg::CNT_W-1:0] dly_ff;
    logic [rds_pkg::OST_W:0]   ost_ff;
    logic [rds_pkg::CNT_W-1:0] lock_ff;
    logic [2:0]         current_oscillator_field_ff;
    logic               tick_d_ff;
    logic               rst_out_ff;
    logic               run_ff;
    logic               rel_ff;
    logic               trap_ff;
    logic               mon_ff;
    logic [23:0]        pc_ff;
    logic               any_src;
    logic               is_power;
    logic               dly_done;
    logic               needs_ost;
    logic               needs_pll;
    logic               ost_done;
    logic               lock_done;
    logic [rds_pkg::CNT_W-1:0] start_len;
    logic               rst_hold;
    logic               rel_nxt;

    // Pin-side inputs cross into the clock domain first
    rds_sync #(.W($bits(rds_pkg::rds_src_t) + 4)) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .d_in    ({reset_sources, osc_tick, pll_locked, clock_valid, sleep_wake}),
        .q_out   ({src_s, tick_s, lock_s, valid_s, wake_s})
    );

    assign any_src   = |src_s; // R1
    assign is_power  = src_s.power_on | src_s.brown_out_reset;
    assign dly_done  = (dly_ff == '0);
    assign start_len = regulator_en ? rds_pkg::CNT_W'(rds_pkg::START_CYC)
                                    : rds_pkg::CNT_W'(PUT_CYCLES); // R7
    assign needs_ost = (current_oscillator_field_ff == rds_pkg::RDS_OSC_XT) || (current_oscillator_field_ff == rds_pkg::RDS_OSC_XTPLL)
                    || (current_oscillator_field_ff == rds_pkg::RDS_OSC_SECONDARY_OSCILLATOR); // R10
    assign needs_pll = (current_oscillator_field_ff == rds_pkg::RDS_OSC_FRCPLL) || (current_oscillator_field_ff == rds_pkg::RDS_OSC_XTPLL)
                    || (current_oscillator_field_ff == rds_pkg::RDS_OSC_ECPLL); // R11
    assign ost_done  = !needs_ost || ost_ff[rds_pkg::OST_W];
    assign lock_done = !needs_pll || (lock_s && lock_ff == '0);
    // Release and run share one next value, so run leads the clock only once trap_ff is set
    assign rel_nxt   = !any_src && ost_done && lock_done && valid_s; // R12

    // Master reset holds through the delay states; monitor wait runs released
    always_comb begin
        unique case (state_ff)
            rds_pkg::RDS_POR,
            rds_pkg::RDS_START,
            rds_pkg::RDS_RST,
            rds_pkg::RDS_IDLE: rst_hold = 1'b1; // R4
            default:           rst_hold = any_src; // R1
        endcase
    end

    // Sequence: hold while sources active, then delays
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            rds_pkg::RDS_IDLE:  if (!any_src) nxt_state = rds_pkg::RDS_RUN;
            rds_pkg::RDS_POR:   if (dly_done) nxt_state = rds_pkg::RDS_START; // R6
            rds_pkg::RDS_START: if (dly_done) nxt_state = rds_pkg::RDS_RST; // R4
            rds_pkg::RDS_RST:   if (dly_done) nxt_state = (needs_ost || needs_pll) ? rds_pkg::RDS_MON
                                                                                : rds_pkg::RDS_RUN; // R9 R14
            rds_pkg::RDS_MON:   if (dly_done) nxt_state = rds_pkg::RDS_RUN; // R14
            rds_pkg::RDS_RUN:   if (wake_s && regulator_en) nxt_state = rds_pkg::RDS_START; // R8
            default:            nxt_state = rds_pkg::RDS_IDLE;
        endcase
        if (any_src) begin
            nxt_state = src_s.power_on ? rds_pkg::RDS_POR
                      : src_s.brown_out_reset ? rds_pkg::RDS_START : rds_pkg::RDS_RST; // R6 R9
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff <= rds_pkg::RDS_IDLE;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // Delay counter reloads on every state entry
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dly_ff <= '0;
        end else if (clk_en) begin
            if (nxt_state != state_ff || any_src) begin
                unique case (nxt_state)
                    rds_pkg::RDS_POR:   dly_ff <= rds_pkg::CNT_W'(rds_pkg::POR_CYC);
                    rds_pkg::RDS_START: dly_ff <= start_len;
                    rds_pkg::RDS_RST:   dly_ff <= rds_pkg::CNT_W'(rds_pkg::RST_CYC);
                    rds_pkg::RDS_MON:   dly_ff <= rds_pkg::CNT_W'(rds_pkg::MON_CYC);
                    default:            dly_ff <= '0;
                endcase
            end else if (!dly_done) begin
                dly_ff <= dly_ff - 1'b1;
            end
        end
    end

    // Clock source choice; sampled while a power-on/brown-out source, or any source with switching off, is active
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            current_oscillator_field_ff <= rds_pkg::OSC_FRC;
        end else if (clk_en) begin
            if (any_src && (!clock_switch_en || is_power)) begin
                current_oscillator_field_ff <= nv_oscillator_select; // R2 R3 R15
            end else if (mon_ff && fail_safe_clock_monitor_en && !valid_s && !trap_ff) begin
                current_oscillator_field_ff <= rds_pkg::OSC_FRC; // R13
            end
        end
    end

    // Start counter and lock wait run beside the reset delays
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ost_ff    <= '0;
            lock_ff   <= rds_pkg::CNT_W'(rds_pkg::LOCK_CYC);
            tick_d_ff <= 1'b0;
        end else if (clk_en) begin
            tick_d_ff <= tick_s;
            if (any_src && is_power) begin
                ost_ff  <= '0;
                lock_ff <= rds_pkg::CNT_W'(rds_pkg::LOCK_CYC);
            end else begin
                if (!ost_done && tick_s && !tick_d_ff) begin
                    ost_ff <= ost_ff + 1'b1; // R5 R10
                end
                // Lock wait starts only once the crystal count ends
                if (ost_done && lock_s && lock_ff != '0) begin
                    lock_ff <= lock_ff - 1'b1; // R5 R11
                end
            end
        end
    end

    // Master reset, release, monitor and CPU start
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rst_out_ff <= 1'b1;
            rel_ff     <= 1'b0;
            run_ff     <= 1'b0;
            mon_ff     <= 1'b0;
            trap_ff    <= 1'b0;
            pc_ff      <= rds_pkg::RESET_VECTOR;
        end else if (clk_en) begin
            rst_out_ff <= rst_hold; // R1 R4
            rel_ff <= rel_nxt;
            if (any_src) begin
                rel_ff  <= 1'b0;
                run_ff  <= 1'b0;
                mon_ff  <= 1'b0;
                trap_ff <= 1'b0;
                pc_ff   <= rds_pkg::RESET_VECTOR; // R16
            end else begin
                // Wake restart drops run in the same cycle the reset rises
                run_ff <= !rst_out_ff && !rst_hold && (rel_nxt || trap_ff); // R12
                if (state_ff == rds_pkg::RDS_RUN && fail_safe_clock_monitor_en) begin
                    mon_ff <= 1'b1; // R14
                end
                if (mon_ff && fail_safe_clock_monitor_en && !valid_s) begin
                    trap_ff <= 1'b1; // R13
                end
            end
        end
    end

    assign master_reset_signal      = rst_out_ff;
    assign cpu_run                  = run_ff;
    assign fetch_address            = pc_ff;
    assign current_oscillator_field = current_oscillator_field_ff;
    assign clock_released           = rel_ff;
    assign clock_fail_trap          = trap_ff;
    assign monitor_active           = mon_ff;
endmodule : rds_sequencer

// ### tb/rds_chk.sv
// Port checker for the reset delay sequencer
`timescale 1ns/1ps
module rds_chk (
    input wire logic         clk_sys,
    input wire logic         rst_n,
    input rds_pkg::rds_src_t reset_sources,
    input wire logic         master_reset_signal,
    input wire logic         cpu_run,
    input wire logic [23:0]  fetch_address,
    input wire logic [2:0]   current_oscillator_field,
    input wire logic         clock_released,
    input wire logic         clock_fail_trap,
    input wire logic         monitor_active
);
    logic [11:0] hi_cnt_ff;
    logic        src_seen_ff;
    // Counted from source drop, so sync delay only lengthens it
    always_ff @(posedge clk_sys) begin
        if (!rst_n || (|reset_sources) || !master_reset_signal) hi_cnt_ff <= 12'h000;
        else if (hi_cnt_ff != 12'hFFF) hi_cnt_ff <= hi_cnt_ff + 12'h001;
    end
    // Release after plain reset involves no delay
    always_ff @(posedge clk_sys) begin
        if (!rst_n) src_seen_ff <= 1'b0;
        else if (|reset_sources) src_seen_ff <= 1'b1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_src_sets_reset: assert property (|reset_sources |-> ##[1:4] master_reset_signal)
        else $error("reset source did not raise master reset");
    a_span_min: assert property ($fell(master_reset_signal) && src_seen_ff |-> hi_cnt_ff >= 12'h1F4)
        else $error("master reset released too early");
    a_run_needs_clk: assert property (cpu_run && !clock_fail_trap |-> clock_released)
        else $error("cpu runs without released clock");
    a_run_no_reset: assert property (cpu_run |-> !master_reset_signal)
        else $error("cpu runs during master reset");
    a_vector_zero: assert property (master_reset_signal |-> fetch_address == 24'h000000)
        else $error("fetch address not zero in reset");
    a_trap_to_frc: assert property ($rose(clock_fail_trap) |-> ##[0:1] current_oscillator_field == 3'h0)
        else $error("trap without fast rc selection");
    a_mon_after_rel: assert property ($rose(monitor_active) |-> !master_reset_signal && !$past(master_reset_signal))
        else $error("monitor started during reset");
    a_trap_sticky: assert property (clock_fail_trap && !(|reset_sources) |=> clock_fail_trap)
        else $error("trap dropped without reset");
endmodule : rds_chk

bind rds_sequencer rds_chk i_rds_chk (.clk_sys(clk_sys), .rst_n(rst_n), .reset_sources(reset_sources),
    .master_reset_signal(master_reset_signal), .cpu_run(cpu_run), .fetch_address(fetch_address),
    .current_oscillator_field(current_oscillator_field), .clock_released(clock_released),
    .clock_fail_trap(clock_fail_trap), .monitor_active(monitor_active));

// ### tb/rds_osc_model.sv
// Oscillator and phase-locked loop model
`timescale 1ns/1ps
module rds_osc_model (
    input  wire logic clk_sys,
    input  wire logic osc_run,
    input  wire logic valid_en,
    output logic      osc_tick,
    output logic      pll_locked,
    output logic      clock_valid
);
    logic [7:0] lock_cnt_ff;
    initial osc_tick = 1'b0;
    // Stopped crystal holds its level
    always_ff @(posedge clk_sys) begin
        if (osc_run) osc_tick <= ~osc_tick;
    end
    // Lock lags oscillator start
    always_ff @(posedge clk_sys) begin
        if (!osc_run) lock_cnt_ff <= 8'h00;
        else if (lock_cnt_ff != 8'hFF) lock_cnt_ff <= lock_cnt_ff + 8'h01;
    end
    assign pll_locked  = lock_cnt_ff == 8'hFF;
    assign clock_valid = osc_run && valid_en;
endmodule : rds_osc_model

// ### tb/testbench.sv
// Self-checking bench for the reset delay sequencer
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
    logic              clk_sys = 1'b0;
    logic              rst_n = 1'b0;
    rds_pkg::rds_src_t src = '0;
    logic              sw_en = 1'b1;
    logic              reg_en = 1'b1;
    logic              mon_en = 1'b0;
    logic [2:0]        nv_sel = 3'h0;
    logic              osc_run = 1'b1;
    logic              wake = 1'b0;
    logic              osc_tick;
    logic              pll_locked;
    logic              clock_valid;
    logic              mrst;
    logic [3:0]        flags;
    logic [23:0]       fetch;
    logic [2:0]        field;
    int                fails = 0;
    int                tests_run = 0;
    int                n;
    int                t;
    always #20 clk_sys = ~clk_sys;
    rds_osc_model i_rds_osc_model (.clk_sys(clk_sys), .osc_run(osc_run), .valid_en(1'b1), .osc_tick(osc_tick),
        .pll_locked(pll_locked), .clock_valid(clock_valid));
    rds_sequencer #(.PUT_CYCLES(100)) i_rds_sequencer (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
        .reset_sources(src), .clock_switch_en(sw_en), .regulator_en(reg_en), .fail_safe_clock_monitor_en(mon_en),
        .nv_oscillator_select(nv_sel), .sleep_wake(wake), .osc_tick(osc_tick), .pll_locked(pll_locked),
        .clock_valid(clock_valid), .master_reset_signal(mrst), .cpu_run(flags[0]), .fetch_address(fetch),
        .current_oscillator_field(field), .clock_released(flags[1]), .clock_fail_trap(flags[3]),
        .monitor_active(flags[2]));
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : tick
    // Flags: 0 run, 1 released, 2 monitor, 3 trap
    task automatic wait_flag(input int i, input int lim);
        n = 0;
        while (flags[i] !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask : wait_flag
    task automatic pulse(input logic [6:0] mask, input int exp);
        src = mask;
        tick(6);
        src = '0;
        n = 0;
        while (mrst === 1'b1 && n < 20000) begin
            tick(1);
            n++;
        end
        `CHECK("reset span", 1'b1, n >= exp && n <= exp + 8)
    endtask : pulse
    // One-cycle wake; span of master reset afterwards
    task automatic wake_check(input int exp);
        wake = 1'b1;
        tick(1);
        wake = 1'b0;
        tick(3);
        n = 0;
        while (mrst === 1'b1 && n < 20000) begin
            tick(1);
            n++;
        end
        `CHECK("wake span", 1'b1, n >= exp && n <= exp + 8)
    endtask : wake_check
    task automatic end_of_test;
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        tick(12);
        rst_n = 1'b1;
        tick(10);
        pulse(7'h40, 1250);
        wait_flag(0, 100);
        `CHECK("fetch", 24'h000000, fetch)
        `CHECK("field", 3'h0, field)
        wake_check(1000);
        reg_en = 1'b0;
        wake_check(0);
        nv_sel = 3'h6;
        pulse(7'h20, 600);
        `CHECK("field", 3'h6, field)
        nv_sel = 3'h1;
        for (int i = 0; i < 5; i++) begin
            pulse(7'h10 >> i, 500);
            `CHECK("field kept", 3'h6, field)
        end
        sw_en = 1'b0;
        pulse(7'h10, 500);
        wait_flag(0, 1000);
        `CHECK("run", 1'b1, flags[0])
        `CHECK("field", 3'h1, field)
        osc_run = 1'b0;
        pulse(7'h40, 850);
        `CHECK("released", 1'b0, flags[1])
        osc_run = 1'b1;
        wait_flag(1, 2000);
        `CHECK("lock wait", 1'b1, n >= 755 && n <= 765)
        sw_en = 1'b1;
        reg_en = 1'b1;
        nv_sel = 3'h2;
        mon_en = 1'b1;
        osc_run = 1'b0;
        pulse(7'h40, 1250);
        `CHECK("released", 1'b0, flags[1])
        `CHECK("run", 1'b0, flags[0])
        osc_run = 1'b1;
        wait_flag(1, 3000);
        t = n;
        `CHECK("start count", 1'b1, n >= 2040 && n <= 2060)
        wait_flag(2, 1000);
        `CHECK("monitor delay", 1'b1, t + n >= 2495 && t + n <= 2515)
        `CHECK("trap", 1'b0, flags[3])
        osc_run = 1'b0;
        pulse(7'h40, 1250);
        wait_flag(3, 3000);
        `CHECK("trap", 1'b1, flags[3])
        `CHECK("field", 3'h0, field)
        end_of_test;
    end
    initial begin
        #(40 * 40000);
        fails++;
        end_of_test;
    end
endmodule : testbench
